// [include/power_down_defs.vh]
// Constants for the power-down and wake-up controller.
`ifndef POWER_DOWN_DEFS_VH
`define POWER_DOWN_DEFS_VH
// =========================================
// Bit positions in the control bytes
`define PWR_ARM_BIT         1
`define PWR_START_BIT       6
`define WAKE_ENABLE_BIT     7
`define WAKE_SOURCE_BIT     4
`define ALT_MAP_BIT         4
// =========================================
// Reset values
`define WAKE_CTRL_RESET     8'h00
// =========================================
// Timing
`define CLK_PERIOD_PS       8000
`define LATCH_TIME_NS       10000
`define LATCH_CYCLES        ((`LATCH_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_VECTOR         16'h007B
`define CALL_MACHINE_CYCLES 2
`define MACHINE_CYCLE_CLKS  6
`endif

// [logic/low_time_qualifier.v]
// Counts how long the selected wake-up pin has been low on a free-running timebase.
`timescale 1ns/1ps
`include "power_down_defs.vh"
module low_time_qualifier #(
  parameter WIDTH  = 16,
  parameter CYCLES = 1250
) (
  input  wire ref_clk,
  input  wire rst_b,
  input  wire enable,
  input  wire pin_level,
  output reg  qualified
);
  reg [WIDTH-1:0] count;

  // =========================================
  // Low-time counter
  // The timebase is ref_clk, assumed independent of the stopped core oscillators.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      count     <= {WIDTH{1'b0}};
      qualified <= 1'b0;
    end else if (!enable || pin_level) begin
      count     <= {WIDTH{1'b0}};
      qualified <= 1'b0;
    end else if (count >= CYCLES[WIDTH-1:0] - 1'b1) begin
      qualified <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

// [logic/power_down_wakeup_control.v]
// Power-down entry, pin holding and wake-up sequencing for the core.
// What this block does, and what it expects of software and of the reset source
// RL1: In power down both oscillators stop; all state is kept frozen.
// RL2: Port latches drive values; alternate outputs hold their last level.
// RL3: Address latch strobe and program store strobe held low in power down.
// RL4: Reset exit resets registers, keeps RAM, restarts both oscillators.
// RL5: Wake-up pin exit restarts oscillators and keeps registers frozen.
// RL6: Software arms with one write, then starts with the next write.
// RL7: A write setting arm and start together never enters power down.
// RL8: Arm and start bits clear themselves and always read as zero.
// RL9: Start write is last; without wake-up enable only reset ends it.
// RL10: Wake-up enable masks all interrupts but keeps individual enables.
// RL11: Software sets map select, writes wake-up control, clears map select.
// RL12: Source select 0 picks interrupt pin zero, 1 picks CAN receive pin.
// RL13: Selected pin must go low for the latch time; then oscillators start.
// RL14: Once the clock is stable the wake-up interrupt at 007B is raised.
// RL15: Strobes stay low until the call; fetches during the call are discarded.
// RL16: After return, execution resumes; timers, CAN and watchdog frozen until then.
// RL17: All interrupts stay disabled from oscillator start until the return.
// RL18: CAN receive pin wake-up follows the same procedure once selected.
// RL19: Software stops any conversion before starting power down entry.
// RL20: Reset used for exit is held long enough for the oscillator to settle.
// RL21: Port 0 drives or floats by code source; port 2 drives data.
// RL22: Pin low-time is measured on a timebase independent of core clocks.
`timescale 1ns/1ps
`include "power_down_defs.vh"
module power_down_wakeup_control #(
  parameter LATCH_CNT_W = 16,
  parameter LATCH_CNT   = `LATCH_CYCLES,
  parameter CALL_CLKS   = `CALL_MACHINE_CYCLES * `MACHINE_CYCLE_CLKS
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        power_control_reg_write,
  input  wire [7:0]  power_control_reg_wdata,
  input  wire        system_config_reg_write,
  input  wire [7:0]  system_config_reg_wdata,
  input  wire        wake_ctrl_write,
  input  wire [7:0]  wake_ctrl_wdata,
  input  wire        osc_stable,
  input  wire        return_from_interrupt,
  input  wire        ext_code_exec,
  input  wire        ext_interrupt_pin_zero,
  input  wire        can_receive_pin,
  input  wire        ale_run,
  input  wire        program_store_strobe_run,
  input  wire [7:0]  port0_run,
  input  wire [7:0]  port2_run,
  input  wire [7:0]  port_alt_run,
  output reg         power_down,
  output reg         osc_enable,
  output reg         core_freeze,
  output reg         periph_freeze,
  output reg         irq_global_mask,
  output reg         wake_irq,
  output reg  [15:0] wake_vector,
  output reg         fetch_discard,
  output reg         ale,
  output reg         program_store_strobe,
  output reg  [7:0]  port0_out,
  output reg  [7:0]  port0_oe_b,
  output reg  [7:0]  port2_out,
  output reg  [7:0]  port_alt_out,
  output reg         power_down_arm,
  output reg         power_down_start,
  output reg         ext_wakeup_enable,
  output reg         wakeup_source_select,
  output reg         alt_map_select
);
  // =========================================
  // States
  localparam ST_RUN   = 3'd0;
  localparam ST_DOWN  = 3'd1;
  localparam ST_OSC   = 3'd2;
  localparam ST_CALL  = 3'd3;
  localparam ST_ISR   = 3'd4;

  reg [2:0]  state;
  reg [2:0]  next_state;
  reg        armed;
  reg [7:0]  call_cnt;
  reg        code_ext;
  reg [7:0]  port0_hold;
  reg [7:0]  port2_hold;
  reg [7:0]  alt_hold;
  wire       qualified;
  wire       sel_pin;
  wire       wr_arm;
  wire       wr_start;
  wire       next_wake_enable;
  reg        next_power_down;
  reg        next_osc_enable;
  reg        next_core_freeze;
  reg        next_periph_freeze;
  reg        next_irq_global_mask;
  reg        next_wake_irq;
  reg        next_fetch_discard;
  reg        next_ale;
  reg        next_program_store_strobe;
  reg [7:0]  next_port0_out;
  reg [7:0]  next_port0_oe_b;
  reg [7:0]  next_port2_out;
  reg [7:0]  next_port_alt_out;
  reg        image_ext;
  reg [7:0]  image_port0;
  reg [7:0]  image_port2;
  reg [7:0]  image_alt;

  assign sel_pin  = wakeup_source_select ? can_receive_pin : ext_interrupt_pin_zero; // [RL12] [RL18]
  assign wr_arm   = power_control_reg_write & power_control_reg_wdata[`PWR_ARM_BIT];
  assign wr_start = power_control_reg_write & power_control_reg_wdata[`PWR_START_BIT];
  assign next_wake_enable = (state == ST_RUN && wake_ctrl_write && alt_map_select) ?
                            wake_ctrl_wdata[`WAKE_ENABLE_BIT] : ext_wakeup_enable;

  // =========================================
  // Low-time qualification of the wake-up pin
  low_time_qualifier #(
    .WIDTH  (LATCH_CNT_W),
    .CYCLES (LATCH_CNT)
  ) u_qual (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .enable    (state == ST_DOWN && ext_wakeup_enable),
    .pin_level (sel_pin),
    .qualified (qualified)
  ); // [RL13] [RL22]

  // =========================================
  // Next state
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // Only a start write right after an arm write, each alone, enters power down.
        if (armed && wr_start && !wr_arm) begin
          next_state = ST_DOWN; // [RL7] [RL9]
        end
      end
      ST_DOWN: begin
        if (ext_wakeup_enable && qualified) begin
          next_state = ST_OSC; // [RL9] [RL13]
        end
      end
      ST_OSC: begin
        if (osc_stable) begin
          next_state = ST_CALL; // [RL14]
        end
      end
      ST_CALL: begin
        if (call_cnt == CALL_CLKS[7:0] - 8'h01) begin
          next_state = ST_ISR;
        end
      end
      ST_ISR: begin
        if (return_from_interrupt) begin
          next_state = ST_RUN; // [RL16]
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // =========================================
  // Sequencer state and call window
  // The call window is counted so the discarded fetches span both machine cycles.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state    <= ST_RUN;
      call_cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (state == ST_CALL) begin
        call_cnt <= call_cnt + 8'h01;
      end else begin
        call_cnt <= 8'h00;
      end
    end
  end

  // =========================================
  // Entry arming
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (state != ST_RUN) begin
      armed <= 1'b0;
    end else if (power_control_reg_write) begin
      // Any write other than a lone arm bit disarms, so a joint write never counts.
      armed <= wr_arm & ~wr_start; // [RL6] [RL7]
    end
  end

  // =========================================
  // Control bits
  // Reset is the only exit that clears the control bits; RAM lies outside this block.
  // Writes are only taken while running; a frozen core cannot issue any.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      power_down_arm       <= 1'b0;
      power_down_start     <= 1'b0;
      ext_wakeup_enable    <= 1'b0;
      wakeup_source_select <= 1'b0;
      alt_map_select       <= 1'b0; // [RL4] [RL12]
    end else begin
      power_down_arm    <= 1'b0;
      power_down_start  <= 1'b0; // [RL8]
      ext_wakeup_enable <= next_wake_enable; // [RL5] [RL11]
      if (state == ST_RUN && system_config_reg_write) begin
        alt_map_select <= system_config_reg_wdata[`ALT_MAP_BIT];
      end
      if (state == ST_RUN && wake_ctrl_write && alt_map_select) begin
        wakeup_source_select <= wake_ctrl_wdata[`WAKE_SOURCE_BIT]; // [RL11] [RL18]
      end
    end
  end

  // =========================================
  // Pin image frozen at entry
  // In the entering cycle the live run values are the image; later the held copy is.
  always @* begin
    if (state == ST_RUN) begin
      image_ext   = ext_code_exec;
      image_port0 = port0_run;
      image_port2 = port2_run;
      image_alt   = port_alt_run;
    end else begin
      image_ext   = code_ext;
      image_port0 = port0_hold;
      image_port2 = port2_hold;
      image_alt   = alt_hold;
    end
  end

  // =========================================
  // Pin image store
  // Capture runs every running cycle, so no separate entry strobe is needed.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      code_ext   <= 1'b0;
      port0_hold <= 8'h00;
      port2_hold <= 8'h00;
      alt_hold   <= 8'h00;
    end else begin
      code_ext   <= image_ext;
      port0_hold <= image_port0;
      port2_hold <= image_port2;
      alt_hold   <= image_alt; // [RL2]
    end
  end

  // =========================================
  // Next output values
  // Decoding the next state lets every pin change on the same edge as the state.
  always @* begin
    next_power_down           = 1'b0;
    next_osc_enable           = 1'b1;
    next_core_freeze          = 1'b0;
    next_periph_freeze        = 1'b1;
    next_irq_global_mask      = 1'b1;
    next_wake_irq             = 1'b0;
    next_fetch_discard        = 1'b0;
    next_ale                  = ale_run;
    next_program_store_strobe = program_store_strobe_run;
    next_port0_out            = port0_run;
    next_port0_oe_b           = 8'h00;
    next_port2_out            = port2_run;
    next_port_alt_out         = port_alt_run;
    case (next_state)
      ST_RUN: begin
        next_periph_freeze   = 1'b0; // [RL16]
        next_irq_global_mask = next_wake_enable; // [RL10]
      end
      ST_DOWN: begin
        next_power_down           = 1'b1;
        next_osc_enable           = 1'b0; // [RL1]
        next_core_freeze          = 1'b1; // [RL1]
        next_ale                  = 1'b0;
        next_program_store_strobe = 1'b0; // [RL3]
        next_port0_out            = image_port0;
        next_port0_oe_b           = image_ext ? 8'hFF : 8'h00; // [RL21]
        next_port2_out            = image_port2; // [RL21]
        next_port_alt_out         = image_alt; // [RL2]
      end
      ST_OSC: begin
        next_core_freeze          = 1'b1; // [RL5]
        next_ale                  = 1'b0;
        next_program_store_strobe = 1'b0; // [RL15]
        next_port0_out            = image_port0;
        next_port0_oe_b           = image_ext ? 8'hFF : 8'h00;
        next_port2_out            = image_port2;
        next_port_alt_out         = image_alt; // [RL2]
      end
      ST_CALL: begin
        next_wake_irq      = (state == ST_OSC); // [RL14]
        next_fetch_discard = 1'b1; // [RL15]
      end
      ST_ISR: begin
        // Other pending interrupts wait until the routine returns.
        next_irq_global_mask = 1'b1; // [RL17]
      end
      default: begin
        next_periph_freeze = 1'b1;
      end
    endcase
  end

  // =========================================
  // Outputs
  // Every pin leaves a flip-flop, so no decode glitch reaches the package.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      power_down           <= 1'b0;
      osc_enable           <= 1'b1;
      core_freeze          <= 1'b0;
      periph_freeze        <= 1'b0;
      irq_global_mask      <= 1'b0;
      wake_irq             <= 1'b0;
      wake_vector          <= `WAKE_VECTOR;
      fetch_discard        <= 1'b0;
      ale                  <= 1'b1;
      program_store_strobe <= 1'b1;
      port0_out            <= 8'h00;
      port0_oe_b           <= 8'hFF;
      port2_out            <= 8'h00;
      port_alt_out         <= 8'h00;
    end else begin
      power_down           <= next_power_down;
      osc_enable           <= next_osc_enable; // [RL1] [RL5]
      core_freeze          <= next_core_freeze; // [RL1] [RL5]
      periph_freeze        <= next_periph_freeze; // [RL16]
      // Global mask covers wake-up enable and the whole wake-up sequence.
      irq_global_mask      <= next_irq_global_mask; // [RL10] [RL17]
      wake_irq             <= next_wake_irq; // [RL14]
      wake_vector          <= `WAKE_VECTOR;
      fetch_discard        <= next_fetch_discard; // [RL15]
      ale                  <= next_ale;
      program_store_strobe <= next_program_store_strobe; // [RL3] [RL15]
      port0_out            <= next_port0_out;
      port0_oe_b           <= next_port0_oe_b; // [RL21]
      port2_out            <= next_port2_out;
      port_alt_out         <= next_port_alt_out; // [RL2] [RL21]
    end
  end
endmodule

// [verification/power_down_wakeup_control_bench.sv]
// Self-checking bench for the power-down and wake-up controller.
`timescale 1ns/1ps
module power_down_wakeup_control_bench;
  // ========
  // Signals
  reg         ref_clk = 1'b0, rst_b = 1'b0, osc_stable = 1'b1, ext_code_exec = 1'b0;
  reg         power_control_reg_write = 1'b0, system_config_reg_write = 1'b0, wake_ctrl_write = 1'b0;
  reg         return_from_interrupt = 1'b0, ale_run = 1'b1, program_store_strobe_run = 1'b1;
  reg [7:0]   power_control_reg_wdata = 8'h00, system_config_reg_wdata = 8'h00, wake_ctrl_wdata = 8'h00, img;
  reg [7:0]   port0_run = 8'h00, port2_run = 8'h00, port_alt_run = 8'h00;
  reg         go = 1'b0, sel = 1'b0;
  reg [11:0]  len = 12'h000;
  wire        ext_interrupt_pin_zero, can_receive_pin, power_down, osc_enable, core_freeze;
  wire        periph_freeze, irq_global_mask, wake_irq, fetch_discard, ale, program_store_strobe;
  wire [15:0] wake_vector;
  wire [7:0]  port0_out, port0_oe_b, port2_out, port_alt_out;
  wire        power_down_arm, power_down_start, ext_wakeup_enable, wakeup_source_select;
  wire        alt_map_select;
  integer     fail_count = 0, checked = 0, i, n;
  always #4 ref_clk = ~ref_clk;
  // A short latch count keeps the run brief; the pulses below are sized from it.
  power_down_wakeup_control #(.LATCH_CNT(4)) u_dut (.*);
  wake_pin_driver u_pin (.ref_clk(ref_clk), .go(go), .sel(sel), .len(len),
    .int_pin(ext_interrupt_pin_zero), .can_pin(can_receive_pin));
  // ========
  // Tasks
  task chk_word(input [8*8:1] what, input [15:0] e, input [15:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task chk_bit(input [8*8:1] what, input e, input g);
    chk_word(what, {15'h0000, e}, {15'h0000, g});
  endtask
  function [7:0] exp_oe(input ext);
    exp_oe = ext ? 8'hFF : 8'h00;
  endfunction
  function pick(input s);
    pick = s ? wake_irq : power_down;
  endfunction
  task step(input integer k);
    begin
      repeat (k) @(posedge ref_clk);
      #1;
    end
  endtask
  task wt(input s, input v);
    begin
      n = 0;
      while (pick(s) !== v && n < 300) begin
        step(1);
        n = n + 1;
      end
      chk_bit("wait", v, pick(s));
    end
  endtask
  task wr(input [1:0] k, input [7:0] d);
    begin
      @(posedge ref_clk);
      power_control_reg_write <= (k == 2'd0);
      system_config_reg_write <= (k == 2'd1);
      wake_ctrl_write <= (k == 2'd2);
      {power_control_reg_wdata, system_config_reg_wdata, wake_ctrl_wdata} <= {d, d, d};
      @(posedge ref_clk);
      {power_control_reg_write, system_config_reg_write, wake_ctrl_write} <= 3'b000;
      #1;
    end
  endtask
  task pulse(input s, input [11:0] l);
    begin
      @(posedge ref_clk);
      sel <= s;
      len <= l;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      step(l + 4);
    end
  endtask
  task final_report;
    begin
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    final_report;
  end
  // ========
  // Tests
  initial begin
    n = $urandom(32'h796a9229);
    step(5);
    rst_b <= 1'b1;
    step(1);
    chk_bit("pd", 1'b0, power_down);
    chk_word("vec", 16'h007B, wake_vector);
    wr(0, 8'h42);
    step(3);
    chk_bit("both", 1'b0, power_down);
    wr(0, 8'h02);
    wr(0, 8'h01);
    wr(0, 8'h40);
    step(3);
    chk_bit("disarm", 1'b0, power_down);
    for (i = 0; i < 8; i = i + 1) begin
      img = $urandom;
      wr(0, img & 8'hBF);
      chk_bit("arm", 1'b0, power_down_arm | power_down_start);
    end
    for (i = 0; i < 3; i = i + 1) begin
      wr(1, 8'h10);
      wr(2, (i < 2) ? {3'b100, i[0], 4'h0} : 8'h00);
      wr(1, 8'h00);
      step(1);
      chk_bit("mask", i < 2, irq_global_mask);
      chk_bit("src", i[0], wakeup_source_select);
      chk_bit("map", 1'b0, alt_map_select);
      img = $urandom;
      port0_run <= img;
      port2_run <= img;
      port_alt_run <= img ^ 8'h5A;
      ext_code_exec <= i[0];
      osc_stable <= 1'b0;
      wr(0, 8'h02);
      wr(0, 8'h40);
      step(1);
      chk_bit("pd", 1'b1, power_down);
      chk_bit("osc", 1'b0, osc_enable);
      chk_bit("strobe", 1'b0, ale | program_store_strobe);
      chk_bit("core", 1'b1, core_freeze);
      port0_run <= ~img;
      port2_run <= ~img;
      port_alt_run <= img;
      step(2);
      chk_word("p2", img, port2_out);
      chk_word("alt", img ^ 8'h5A, port_alt_out);
      chk_word("p0oe", exp_oe(i[0]), port0_oe_b);
      chk_word("p0", img, port0_out);
      pulse(~i[0], 12'd20);
      chk_bit("wrong", 1'b1, power_down);
      pulse(i[0], 12'd2);
      chk_bit("short", 1'b1, power_down);
      pulse(i[0], 12'd6);
      if (i < 2) begin
        wt(1'b0, 1'b0);
        chk_bit("osc", 1'b1, osc_enable);
        chk_bit("ale", 1'b0, ale);
        osc_stable <= 1'b1;
        wt(1'b1, 1'b1);
        chk_bit("disc", 1'b1, fetch_discard);
        chk_bit("cfrz", 1'b0, core_freeze);
        step(20);
        chk_bit("frz", 1'b1, periph_freeze);
        chk_bit("imask", 1'b1, irq_global_mask);
        return_from_interrupt <= 1'b1;
        step(1);
        return_from_interrupt <= 1'b0;
        step(3);
        chk_bit("run", 1'b0, periph_freeze);
        chk_bit("kept", 1'b1, ext_wakeup_enable);
      end else begin
        chk_bit("stay", 1'b1, power_down);
        rst_b <= 1'b0;
        step(5);
        rst_b <= 1'b1;
        step(1);
        chk_bit("rst", 1'b0, power_down);
        chk_bit("rosc", 1'b1, osc_enable);
      end
    end
    final_report;
  end
endmodule

// [verification/power_down_wakeup_control_sva.sv]
// Port assertions for the power-down controller.
`timescale 1ns/1ps
module power_down_wakeup_control_sva (
  input wire        ref_clk,
  input wire        rst_b,
  input wire        power_control_reg_write,
  input wire [7:0]  power_control_reg_wdata,
  input wire        osc_stable,
  input wire        power_down,
  input wire        osc_enable,
  input wire        periph_freeze,
  input wire        irq_global_mask,
  input wire        wake_irq,
  input wire [15:0] wake_vector,
  input wire        fetch_discard,
  input wire        ale,
  input wire        program_store_strobe,
  input wire [7:0]  port2_out,
  input wire [7:0]  port_alt_out,
  input wire        power_down_arm,
  input wire        power_down_start,
  input wire        ext_wakeup_enable
);
  // ========
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Only a running core may arm; writes during wake-up do not count.
  sequence arm_s; power_control_reg_write && power_control_reg_wdata == 8'h02 && !power_down && !periph_freeze; endsequence
  sequence start_s; power_control_reg_write && power_control_reg_wdata == 8'h40; endsequence
  entry_seq_a: assert property (arm_s ##1 !power_control_reg_write ##1 start_s |=> power_down)
    else $error("entry sequence ignored");
  both_bits_a: assert property (!power_down && power_control_reg_write && power_control_reg_wdata[1] && power_control_reg_wdata[6]
    |=> !power_down) else $error("entered on joint write");
  self_clear_a: assert property (!power_down_arm && !power_down_start)
    else $error("arm or start reads one");
  strobes_low_a: assert property (power_down |-> !ale && !program_store_strobe)
    else $error("strobe high in power down");
  osc_stop_a: assert property (power_down |-> !osc_enable) else $error("osc runs");
  hold_pins_a: assert property (power_down && $past(power_down) |->
    $stable(port2_out) && $stable(port_alt_out)) else $error("pins moved");
  wake_mask_a: assert property (ext_wakeup_enable |-> irq_global_mask)
    else $error("irq not masked");
  vector_a: assert property (wake_vector == 16'h007B) else $error("bad vector");
  call_pulse_a: assert property ($rose(wake_irq) |-> $past(osc_stable) && fetch_discard
    ##1 !wake_irq) else $error("bad wake call");
  freeze_mask_a: assert property (power_down || wake_irq |-> irq_global_mask
    && periph_freeze) else $error("not frozen");
endmodule
bind power_down_wakeup_control power_down_wakeup_control_sva u_sva (
  .ref_clk              (ref_clk),
  .rst_b                (rst_b),
  .power_control_reg_write           (power_control_reg_write),
  .power_control_reg_wdata           (power_control_reg_wdata),
  .osc_stable           (osc_stable),
  .power_down           (power_down),
  .osc_enable           (osc_enable),
  .periph_freeze        (periph_freeze),
  .irq_global_mask      (irq_global_mask),
  .wake_irq             (wake_irq),
  .wake_vector          (wake_vector),
  .fetch_discard        (fetch_discard),
  .ale                  (ale),
  .program_store_strobe (program_store_strobe),
  .port2_out            (port2_out),
  .port_alt_out         (port_alt_out),
  .power_down_arm       (power_down_arm),
  .power_down_start     (power_down_start),
  .ext_wakeup_enable    (ext_wakeup_enable)
);

// [verification/wake_pin_driver.sv]
// Model of the party that drives the two wake-up pins.
`timescale 1ns/1ps
module wake_pin_driver (
  input  wire        ref_clk,
  input  wire        go,
  input  wire        sel,
  input  wire [11:0] len,
  output reg         int_pin,
  output reg         can_pin
);
  // ========
  // Pulse timer
  reg [11:0] cnt = 12'h000;
  wire       low = go || (cnt > 12'h001);
  initial begin
    int_pin = 1'b1;
    can_pin = 1'b1;
  end
  // Both pins rest high; one selected pin goes low for len cycles.
  always @(posedge ref_clk) begin
    if (go) cnt <= len;
    else if (cnt != 12'h000) cnt <= cnt - 12'h001;
    int_pin <= !(low && !sel);
    can_pin <= !(low && sel);
  end
endmodule
